// file: pkg/serial_link_cfg_pkg.sv
// package for the serial link configuration register bank
// assumes a plain register port with 10-bit byte addresses and 8-bit data
package serial_link_cfg_pkg;
    localparam int          ADDR_W            = 10;
    localparam int          DATA_W            = 8;
    // register offsets
    localparam logic [9:0]  OFF_LINK_ENABLE   = 10'h200;
    localparam logic [9:0]  OFF_OUTPUT_MODE   = 10'h201;
    localparam logic [9:0]  OFF_FRAMES_PER_MF = 10'h202;
    localparam logic [9:0]  OFF_MANUAL_SYNC   = 10'h203;
    localparam logic [9:0]  OFF_LINK_CONTROL  = 10'h204;
    localparam logic [9:0]  OFF_TEST_PATTERN  = 10'h205;
    localparam logic [9:0]  OFF_DEVICE_ID     = 10'h206;
    localparam logic [9:0]  OFF_AUX_CONTROL   = 10'h210;
    localparam logic [9:0]  OFF_LINK_STATUS   = 10'h211;
    // reset values
    localparam logic [7:0]  RST_LINK_ENABLE   = 8'h01;
    localparam logic [4:0]  RST_OUTPUT_MODE   = 5'h02;
    localparam logic [4:0]  RST_FRAMES_PER_MF = 5'h1F;
    localparam logic        RST_MANUAL_SYNC   = 1'b1;
    localparam logic [1:0]  RST_SYNC_SEL      = 2'h0;
    localparam logic        RST_SAMPLE_FMT    = 1'b1;
    localparam logic        RST_SCRAMBLE      = 1'b0;
    localparam logic [3:0]  RST_TEST_PATTERN  = 4'h0;
    localparam logic [7:0]  RST_DEVICE_ID     = 8'h00;
    localparam logic [1:0]  RST_AUX_CONTROL   = 2'h0;
    // field positions in link control
    localparam int          POS_SCRAMBLE      = 0;
    localparam int          POS_SAMPLE_FMT    = 1;
    localparam int          POS_SYNC_SEL      = 2;
    // field positions in aux control
    localparam int          POS_CAL_EN        = 0;
    localparam int          POS_TS_RECV_EN    = 1;
    localparam logic [7:0]  READ_UNMAPPED     = 8'h00;
    localparam logic [4:0]  FIVE_BIT_ONE      = 5'h01;
    localparam logic [7:0]  DEVICE_ID_EVEN    = 8'hFE;
    localparam logic [7:0]  DEVICE_ID_STEP    = 8'h02;
    localparam logic        SYNC_IDLE_N       = 1'b1;

    typedef enum logic [1:0]
    {
        SYNC_FROM_SINGLE = 2'b00,
        SYNC_FROM_DIFF   = 2'b01,
        SYNC_FROM_SOFT   = 2'b10,
        SYNC_FROM_RSVD   = 2'b11
    } sync_source_e;

    typedef enum logic [3:0]
    {
        PAT_NORMAL     = 4'b0000,
        PAT_PRBS7      = 4'b0001,
        PAT_PRBS15     = 4'b0010,
        PAT_PRBS23     = 4'b0011,
        PAT_RAMP       = 4'b0100,
        PAT_TRANSPORT  = 4'b0101,
        PAT_D21_5      = 4'b0110,
        PAT_K28_5      = 4'b0111,
        PAT_REPEAT_ILA = 4'b1000,
        PAT_MOD_RPAT   = 4'b1001,
        PAT_HOLD_LOW   = 4'b1010,
        PAT_HOLD_HIGH  = 4'b1011
    } test_pattern_e;

    // configuration handed to the link logic
    typedef struct packed
    {
        logic [4:0]    output_mode_field;
        logic [4:0]    multiframe_length_minus_one;
        logic [5:0]    frames_per_multiframe;
        logic          sample_format_bit;
        logic          scrambler_enable;
        test_pattern_e test_pattern_field;
        logic          test_pattern_reserved;
        logic [7:0]    link_a_device_id;
        logic [7:0]    link_b_device_id;
    } link_config_s;
endpackage : serial_link_cfg_pkg

// file: core/serial_link_config_regs.sv
// register bank configuring the serial output link
// assumes a synchronous single-clock register port and synchronous sync pins
// writes are never blocked: software keeps the link disabled while reprogramming
// o_config and the link controls trail the registers by one clock
// Behaviour
// (R1) five-bit output mode field, resets to 2
// (R2) software changes mode only when link, calibration off
// (R3) multiframe length holds frames minus one
// (R4) software programs frame counts legal for mode
// (R5) software alters link registers only while disabled
// (R6) sync select 0 uses single-ended sync input
// (R7) sync select 1 uses differential timestamp input
// (R8) sync select 2 uses software sync bit
// (R9) sample format: 0 offset binary, 1 twos
// (R10) control bit 0 enables scrambler, reset off
// (R11) patterns 0 normal, 1-3 PRBS7/15/23
// (R12) patterns 4-7 ramp, transport, D21.5, K28.5
// (R13) patterns 8-11 ILA, RPAT, low, high
// (R14) device ID sent in second alignment multiframe
// (R15) link A sends ID, link B ID+1
// (R16) device ID bit 0 ignored, reads zero
// (R17) software sync bit active low, resets high
// (R18) link disabled holds link block in reset
`timescale 1ns/1ps
`default_nettype none

module serial_link_config_regs
    import serial_link_cfg_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_write,
    input  wire logic              i_read,
    output var  logic [DATA_W-1:0] o_rdata,
    input  wire logic              i_single_ended_sync_n,
    input  wire logic              i_differential_timestamp_n,
    output var  logic              o_link_sync_request_n,
    output var  logic              o_link_reset,
    output var  logic              o_serializer_power_down,
    output var  logic              o_calibration_enable,
    output var  logic              o_timestamp_receiver_enable,
    output var  link_config_s      o_config
);

    //--------------------------------------------------------------
    // register storage
    //--------------------------------------------------------------
    logic          serial_interface_enable_reg;
    logic [4:0]    output_mode_field_reg;
    logic [4:0]    multiframe_length_minus_one_reg;
    logic          software_sync_request_reg;
    sync_source_e  sync_select_reg;
    logic          sample_format_bit_reg;
    logic          scrambler_enable_reg;
    logic [3:0]    test_pattern_field_reg;
    logic [7:0]    lane_alignment_device_id_reg;
    logic          calibration_enable_reg;
    logic          timestamp_receiver_enable_reg;
    logic          sync_selected_next;
    logic [DATA_W-1:0] rdata_next;

    // byte address match for a write
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // device id with bit zero cleared; used on write and on read-back
    function automatic logic [DATA_W-1:0] even_id(input logic [DATA_W-1:0] v);
        even_id = v & DEVICE_ID_EVEN;
    endfunction : even_id

    // frames per multiframe from the stored length, widened so 31 gives 32
    function automatic logic [5:0] frames_from_length(input logic [4:0] km);
        frames_from_length = {1'b0, km} + {1'b0, FIVE_BIT_ONE};
    endfunction : frames_from_length

    //--------------------------------------------------------------
    // register writes
    //--------------------------------------------------------------
    // enable and calibration
    // calibration and timestamp receiver enables sit in a block-local aux register
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            // (R18) link enabled out of reset
            serial_interface_enable_reg   <= RST_LINK_ENABLE[0];
            calibration_enable_reg        <= RST_AUX_CONTROL[POS_CAL_EN];
            timestamp_receiver_enable_reg <= RST_AUX_CONTROL[POS_TS_RECV_EN];
        end
        else if (i_write)
        begin
            if (hit(i_addr, OFF_LINK_ENABLE))
            begin
                // (R18) clearing this holds the link
                serial_interface_enable_reg <= i_wdata[0];
            end
            if (hit(i_addr, OFF_AUX_CONTROL))
            begin
                calibration_enable_reg        <= i_wdata[POS_CAL_EN];
                timestamp_receiver_enable_reg <= i_wdata[POS_TS_RECV_EN];
            end
        end
    end

    // output mode and multiframe length; caller keeps link disabled
    // reserved bits 7:5 are not stored, so they read back as zero
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            // (R1) mode reset value
            output_mode_field_reg           <= RST_OUTPUT_MODE;
            // (R3) default 32 frames
            multiframe_length_minus_one_reg <= RST_FRAMES_PER_MF;
        end
        else if (i_write)
        begin
            if (hit(i_addr, OFF_OUTPUT_MODE))
            begin
                // (R1) five-bit mode field
                output_mode_field_reg <= i_wdata[4:0];
            end
            if (hit(i_addr, OFF_FRAMES_PER_MF))
            begin
                // (R3) stored as frames minus one
                multiframe_length_minus_one_reg <= i_wdata[4:0];
            end
        end
    end

    // manual sync and link control
    // the software request is kept as written; it only acts with select 2
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            // (R17) deasserted at reset
            software_sync_request_reg <= RST_MANUAL_SYNC;
            sync_select_reg           <= sync_source_e'(RST_SYNC_SEL);
            // (R9) twos complement default
            sample_format_bit_reg     <= RST_SAMPLE_FMT;
            // (R10) scrambler off default
            scrambler_enable_reg      <= RST_SCRAMBLE;
        end
        else if (i_write)
        begin
            if (hit(i_addr, OFF_MANUAL_SYNC))
            begin
                // (R17) active-low request bit
                software_sync_request_reg <= i_wdata[0];
            end
            if (hit(i_addr, OFF_LINK_CONTROL))
            begin
                // (R6) (R7) (R8) source select
                sync_select_reg       <= sync_source_e'(i_wdata[POS_SYNC_SEL +: 2]);
                // (R9) sample format
                sample_format_bit_reg <= i_wdata[POS_SAMPLE_FMT];
                // (R10) scrambler switch
                scrambler_enable_reg  <= i_wdata[POS_SCRAMBLE];
            end
        end
    end

    // test pattern and device id
    // reserved pattern codes are stored so a read-back shows what was written
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            test_pattern_field_reg       <= RST_TEST_PATTERN;
            // (R14) id starts at zero
            lane_alignment_device_id_reg <= RST_DEVICE_ID;
        end
        else if (i_write)
        begin
            if (hit(i_addr, OFF_TEST_PATTERN))
            begin
                // (R11) (R12) (R13) pattern code
                test_pattern_field_reg <= i_wdata[3:0];
            end
            if (hit(i_addr, OFF_DEVICE_ID))
            begin
                // (R16) drop bit zero
                lane_alignment_device_id_reg <= even_id(i_wdata);
            end
        end
    end

    //--------------------------------------------------------------
    // sync source selection
    //--------------------------------------------------------------
    // reserved select keeps the request idle, so no stray resync starts
    always_comb
    begin
        case (sync_select_reg)
            // (R6) single-ended pin
            SYNC_FROM_SINGLE: sync_selected_next = i_single_ended_sync_n;
            // (R7) differential pin
            SYNC_FROM_DIFF:   sync_selected_next = i_differential_timestamp_n;
            // (R8) software bit only
            // (R17) active-low software request
            SYNC_FROM_SOFT:   sync_selected_next = software_sync_request_reg;
            default:          sync_selected_next = SYNC_IDLE_N;
        endcase
    end

    // registered sync request; idle while link held in reset
    // forcing idle while disabled keeps a stale pin level off the link
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            o_link_sync_request_n <= SYNC_IDLE_N;
        else
            o_link_sync_request_n <= serial_interface_enable_reg ? sync_selected_next
                                                                 : SYNC_IDLE_N;
    end

    //--------------------------------------------------------------
    // link control outputs
    //--------------------------------------------------------------
    // reset and power-down move together, one clock after the enable
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_link_reset                <= ~RST_LINK_ENABLE[0];
            o_serializer_power_down     <= ~RST_LINK_ENABLE[0];
            o_calibration_enable        <= RST_AUX_CONTROL[POS_CAL_EN];
            o_timestamp_receiver_enable <= RST_AUX_CONTROL[POS_TS_RECV_EN];
        end
        else
        begin
            // (R18) disable resets link
            o_link_reset                <= ~serial_interface_enable_reg;
            o_serializer_power_down     <= ~serial_interface_enable_reg;
            o_calibration_enable        <= calibration_enable_reg;
            o_timestamp_receiver_enable <= timestamp_receiver_enable_reg;
        end
    end

    // configuration bundle for the link logic
    // registered so the link logic sees every field change on one edge
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            o_config <= '0;
        else
        begin
            o_config.output_mode_field           <= output_mode_field_reg;
            o_config.multiframe_length_minus_one <= multiframe_length_minus_one_reg;
            // (R3) frames is field plus one
            o_config.frames_per_multiframe       <=
                frames_from_length(multiframe_length_minus_one_reg);
            // (R9) sample format select
            o_config.sample_format_bit           <= sample_format_bit_reg;
            // (R10) scrambler switch
            o_config.scrambler_enable            <= scrambler_enable_reg;
            // (R11) (R12) (R13) pattern select
            o_config.test_pattern_field          <= test_pattern_e'(test_pattern_field_reg);
            // (R13) codes 12 to 15 reserved
            o_config.test_pattern_reserved       <= (test_pattern_field_reg > PAT_HOLD_HIGH);
            // (R14) id for second multiframe
            o_config.link_a_device_id            <= lane_alignment_device_id_reg;
            // (R15) link b sends id plus one
            o_config.link_b_device_id            <= lane_alignment_device_id_reg + 8'h01;
        end
    end

    //--------------------------------------------------------------
    // register reads
    //--------------------------------------------------------------
    // reserved bits and unmapped addresses read as zero
    always_comb
    begin
        case (i_addr)
            OFF_LINK_ENABLE:   rdata_next = {7'h00, serial_interface_enable_reg};
            OFF_OUTPUT_MODE:   rdata_next = {3'h0, output_mode_field_reg};
            OFF_FRAMES_PER_MF: rdata_next = {3'h0, multiframe_length_minus_one_reg};
            OFF_MANUAL_SYNC:   rdata_next = {7'h00, software_sync_request_reg};
            OFF_LINK_CONTROL:  rdata_next = {4'h0, sync_select_reg,
                                             sample_format_bit_reg, scrambler_enable_reg};
            OFF_TEST_PATTERN:  rdata_next = {4'h0, test_pattern_field_reg};
            // (R16) bit zero reads zero
            OFF_DEVICE_ID:     rdata_next = even_id(lane_alignment_device_id_reg);
            OFF_AUX_CONTROL:   rdata_next = {6'h00, timestamp_receiver_enable_reg,
                                             calibration_enable_reg};
            OFF_LINK_STATUS:   rdata_next = {6'h00, o_link_sync_request_n, o_link_reset};
            default:           rdata_next = READ_UNMAPPED;
        endcase
    end

    // read data one cycle after the strobe, zero otherwise
    // zero outside the answer cycle keeps an or-ed read bus clean
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            o_rdata <= READ_UNMAPPED;
        else
            o_rdata <= i_read ? rdata_next : READ_UNMAPPED;
    end

endmodule : serial_link_config_regs
`default_nettype wire

// file: sim/serial_link_config_regs_checker.sv
// checker for the serial link configuration bank
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module serial_link_config_regs_checker
    import serial_link_cfg_pkg::*;
(
    input wire logic              i_clk_sys,
    input wire logic              i_reset_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_write,
    input wire logic              i_read,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              o_link_sync_request_n,
    input wire logic              o_link_reset,
    input wire logic              o_serializer_power_down,
    input wire link_config_s      o_config
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    property p_mode_mask;
        i_read && i_addr == OFF_OUTPUT_MODE |=> o_rdata[7:5] == 3'h0;
    endproperty
    a_mode_mask: assert property (p_mode_mask)
        else $error("mode spare bits not zero");
    property p_mode_cfg;
        i_write && i_addr == OFF_OUTPUT_MODE |-> ##2
            o_config.output_mode_field == $past(i_wdata[4:0], 2);
    endproperty
    a_mode_cfg: assert property (p_mode_cfg)
        else $error("mode field not applied");
    property p_frames;
        $past(i_reset_n) |-> o_config.frames_per_multiframe ==
            {1'b0, o_config.multiframe_length_minus_one} + 6'h01;
    endproperty
    a_frames: assert property (p_frames)
        else $error("frame count not length plus one");
    property p_fmt_scr;
        i_write && i_addr == OFF_LINK_CONTROL |-> ##2
            {o_config.sample_format_bit, o_config.scrambler_enable} == $past(i_wdata[1:0], 2);
    endproperty
    a_fmt_scr: assert property (p_fmt_scr)
        else $error("format or scrambler not applied");
    property p_pattern;
        i_write && i_addr == OFF_TEST_PATTERN |-> ##2
            o_config.test_pattern_field == $past(i_wdata[3:0], 2);
    endproperty
    a_pattern: assert property (p_pattern)
        else $error("pattern not applied");
    property p_reserved;
        $past(i_reset_n) |-> o_config.test_pattern_reserved == (o_config.test_pattern_field > 4'hB);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved pattern flag wrong");
    property p_id_even;
        i_read && i_addr == OFF_DEVICE_ID |=> !o_rdata[0];
    endproperty
    a_id_even: assert property (p_id_even)
        else $error("device id bit 0 read as one");
    property p_id_pair;
        $past(i_reset_n) |-> !o_config.link_a_device_id[0] &&
            o_config.link_b_device_id == o_config.link_a_device_id + 8'h01;
    endproperty
    a_id_pair: assert property (p_id_pair)
        else $error("second link id not first plus one");
    property p_disabled;
        o_link_reset |-> o_serializer_power_down && o_link_sync_request_n;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled link not held");
endmodule : serial_link_config_regs_checker
bind serial_link_config_regs serial_link_config_regs_checker u_serial_link_config_regs_checker (
    .i_clk_sys, .i_reset_n, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
    .o_link_sync_request_n, .o_link_reset, .o_serializer_power_down, .o_config);
`default_nettype wire

// file: sim/sync_receiver_model.sv
// link receiver model raising sync requests on the two pins
// assumes the bench commands each request, active high
`timescale 1ns/1ps
`default_nettype none
module sync_receiver_model
(
    input  wire logic i_clk_sys,
    input  wire logic i_se_req,
    input  wire logic i_diff_req,
    output var  logic o_single_ended_sync_n      = 1'b1,
    output var  logic o_differential_timestamp_n = 1'b1
);
    always_ff @(posedge i_clk_sys)
    begin
        o_single_ended_sync_n      <= !i_se_req;
        o_differential_timestamp_n <= !i_diff_req;
    end
endmodule : sync_receiver_model
`default_nettype wire

// file: sim/serial_link_config_regs_test.sv
// self-checking bench for the serial link configuration bank
// assumes the receiver model drives the sync pins
`timescale 1ns/1ps
`default_nettype none
module serial_link_config_regs_test
    import serial_link_cfg_pkg::*;
;
    logic              i_clk_sys = 1'b0;
    logic              i_reset_n = 1'b0;
    logic [9:0]        addr      = 10'h000;
    logic [7:0]        wdata     = 8'h00;
    logic              wr        = 1'b0;
    logic              rd        = 1'b0;
    logic              rd_seen   = 1'b0;
    logic              se_req    = 1'b0;
    logic              diff_req  = 1'b0;
    logic [7:0]        rdata;
    logic              se_n, diff_n, sync_n, link_rst, pwr_dn, cal_en, ts_en;
    link_config_s      cfg;
    logic [7:0]        exp_q[$];
    logic [7:0]        wv[7];
    int                bad_count = 0;
    int                samples_checked = 0;
    logic [31:0]       seed = 32'h0000_3B32;
    localparam logic [9:0] OFFS [7] = '{10'h200, 10'h201, 10'h202, 10'h203, 10'h204, 10'h205, 10'h206};
    localparam logic [7:0] RSTS [7] = '{8'h01, 8'h02, 8'h1F, 8'h01, 8'h02, 8'h00, 8'h00};
    localparam logic [7:0] MSKS [7] = '{8'h01, 8'h1F, 8'h1F, 8'h01, 8'h0F, 8'h0F, 8'hFE};

    initial forever #2.5 i_clk_sys = ~i_clk_sys;

    serial_link_config_regs u_serial_link_config_regs (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wdata),
        .i_write(wr), .i_read(rd), .o_rdata(rdata), .i_single_ended_sync_n(se_n),
        .i_differential_timestamp_n(diff_n), .o_link_sync_request_n(sync_n),
        .o_link_reset(link_rst), .o_serializer_power_down(pwr_dn),
        .o_calibration_enable(cal_en), .o_timestamp_receiver_enable(ts_en), .o_config(cfg));
    sync_receiver_model u_sync_receiver_model (
        .i_clk_sys(i_clk_sys), .i_se_req(se_req), .i_diff_req(diff_req),
        .o_single_ended_sync_n(se_n), .o_differential_timestamp_n(diff_n));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // one bus cycle, strobes released at the next edge
    task automatic bus(input logic [9:0] a, input logic [7:0] d, input logic w);
        @(posedge i_clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge i_clk_sys);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        bus(a, d, 1'b1);
    endtask : wr_reg
    task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b0);
    endtask : rd_reg
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask : settle
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // read data monitor takes the oldest expectation
    always @(posedge i_clk_sys)
        rd_seen <= rd;
    always @(negedge i_clk_sys)
        if (rd_seen)
            check_val(rdata, exp_q.pop_front());

    initial
    begin
        repeat (5) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd_reg(OFFS[i], RSTS[i]);
        rd_reg(10'h20C, 8'h00);
        settle(1);
        check_val({2'h0, cfg.frames_per_multiframe}, 8'h20);
        wr_reg(OFF_LINK_ENABLE, 8'h00);
        se_req <= 1'b1;
        settle(3);
        check_val({5'h00, link_rst, pwr_dn, sync_n}, 8'h07);
        rd_reg(OFF_LINK_STATUS, 8'h03);
        // lengths taken as legal for mode
        for (int i = 1; i < 7; i++)
        begin
            seed = xs(seed);
            wv[i] = seed[7:0];
            wr_reg(OFFS[i], wv[i]);
            rd_reg(OFFS[i], wv[i] & MSKS[i]);
        end
        settle(1);
        check_val({3'h0, cfg.output_mode_field}, wv[1] & 8'h1F);
        check_val({2'h0, cfg.frames_per_multiframe}, {3'h0, wv[2][4:0]} + 8'h01);
        check_val({6'h00, cfg.sample_format_bit, cfg.scrambler_enable}, wv[4] & 8'h03);
        check_val(cfg.link_a_device_id, wv[6] & 8'hFE);
        wr_reg(OFF_DEVICE_ID, 8'hFF);
        rd_reg(OFF_DEVICE_ID, 8'hFE);
        settle(1);
        check_val(cfg.link_b_device_id, 8'hFF);
        for (int p = 0; p < 16; p++)
        begin
            wr_reg(OFF_TEST_PATTERN, 8'(p));
            settle(1);
            check_val({3'h0, cfg.test_pattern_reserved, cfg.test_pattern_field},
                8'(p) | ((p > 11) ? 8'h10 : 8'h00));
        end
        wr_reg(OFF_AUX_CONTROL, 8'h03);
        settle(1);
        check_val({6'h00, ts_en, cal_en}, 8'h03);
        rd_reg(OFF_AUX_CONTROL, 8'h03);
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(OFF_LINK_ENABLE, 8'h00);
            wr_reg(OFF_LINK_CONTROL, {4'h0, 2'(s), 2'b10});
            wr_reg(OFF_LINK_ENABLE, 8'h01);
            for (int k = 0; k < 3; k++)
            begin
                se_req   <= (k == 0);
                diff_req <= (k == 1);
                wr_reg(OFF_MANUAL_SYNC, (k == 2) ? 8'h00 : 8'h01);
                settle(3);
                check_val({7'h00, sync_n}, (s == k) ? 8'h00 : 8'h01);
            end
        end
        test_done();
    end

    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        bad_count++;
        test_done();
    end
endmodule : serial_link_config_regs_test
`default_nettype wire
